// file: core/ccr_consts.svh
// named constants for the charger configuration register pair
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

// ==========================================================
// register offsets
`define CCR_ADDR_CFG0 8'h16
`define CCR_ADDR_CFG1 8'h17

// ==========================================================
// field positions, first configuration register
`define CCR_B_SWOFF 6
`define CCR_B_STBY 5
`define CCR_B_WDT 4
`define CCR_MODE_HI 3
`define CCR_MODE_LO 0

// ==========================================================
// field positions, second configuration register
`define CCR_B_PREQUAL_ENABLE 7
`define CCR_B_PQTMR 6
`define CCR_RSTRT_HI 5
`define CCR_RSTRT_LO 4
`define CCR_B_STAT 3
`define CCR_FC_HI 2
`define CCR_FC_LO 0

// ==========================================================
// reset values
`define CCR_RST_MODE 4'h5
`define CCR_RST_CFG1 8'hd9

// ==========================================================
// power-path mode codes
`define CCR_MODE_OFF_HI 4'h3
`define CCR_MODE_DCDC 4'h4
`define CCR_MODE_CHG_LO 4'h5
`define CCR_MODE_CHG_HI 4'h7
`define CCR_MODE_OTG 4'ha

// ==========================================================
// recharge threshold decode, mV per cell
`define CCR_RSTRT_OFF 2'h3
`define CCR_RSTRT_MV0 8'h64
`define CCR_RSTRT_MV1 8'h96
`define CCR_RSTRT_MV2 8'hc8
`define CCR_RSTRT_MV_NONE 8'h00

// ==========================================================
// fast-charge timer decode, hours
`define CCR_FC_OFF 3'h0
`define CCR_FC_CODE_MAX 3'h7
`define CCR_FC_HR_OFFSET 4'h2
`define CCR_FC_HR_MAX 4'ha
`define CCR_FC_HR_NONE 4'h0

// ==========================================================
// watchdog period
`define CCR_CLK_HZ 50000000
`define CCR_WDT_PERIOD_S 2

`endif

// file: core/ccr_pkg.sv
// types shared by the charger configuration register block
package ccr_pkg;
   typedef logic [3:0] ccr_mode_t;
   typedef logic [7:0] ccr_byte_t;
endpackage

// file: core/ccr_charger_config_regs.sv
// charger configuration registers with power-path decode and watchdog
// Overview of operation
// - bit 6 of config 0 forces battery-to-system switch off; 0 leaves it automatic
// - switch-off readback is register bit ORed with the external disable pin
// - standby bit 5 forces DC-DC off into input standby; 0 automatic
// - standby readback returns the standby setting actually in force
// - bit 4 enables watchdog; charger runs only while watchdog is serviced
// - mode 0x0-0x3 turns charger, OTG and DC-DC off; battery feeds system
// - mode 0x4 runs DC-DC only, charger and OTG off
// - mode 0x5-0x7 enables charger and DC-DC, OTG off
// - mode 0xA runs reverse buck OTG, forward path off, battery switch kept on
// - mode field readback returns the configuration actually applied
// - config 1 bit 7 enables low-battery prequalification
// - bit 6 enables prequal timer; off means no timer fault in prequal
// - bits 5:4 select recharge threshold 100/150/200 mV per cell or disabled
// - bit 3 enables the charge indicator output
// - fast-charge timer code 0 disables; 1..7 give 3,4,5,6,7,8,10 hours
`timescale 1ns/1ps
`include "ccr_consts.svh"

module ccr_charger_config_regs
   import ccr_pkg::*;
#(
   parameter int WDT_CYCLES = `CCR_WDT_PERIOD_S * `CCR_CLK_HZ,
   parameter int WDT_W = 27
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_ack_out,
   input wire logic battery_switch_disable_pin_in,
   input wire logic watchdog_clear_in,
   output logic batt_sys_switch_off_out,
   output logic batt_switch_keep_on_out,
   output logic input_standby_force_out,
   output logic charger_en_out,
   output logic dcdc_en_out,
   output logic otg_en_out,
   output logic watchdog_expired_out,
   output logic prequal_enable_out,
   output logic prequal_timer_enable_out,
   output logic [1:0] recharge_threshold_sel_out,
   output logic [7:0] recharge_mv_per_cell_out,
   output logic stat_output_enable_out,
   output logic [2:0] fast_charge_timeout_sel_out,
   output logic [3:0] fast_charge_hours_out
);

   // ==========================================================
   // decode helpers
   function automatic logic mode_reserved(input ccr_mode_t m);
      mode_reserved = (m > `CCR_MODE_CHG_HI) && (m != `CCR_MODE_OTG);
   endfunction

   function automatic logic [3:0] fc_hours(input logic [2:0] c);
      if (c == `CCR_FC_OFF) begin
         fc_hours = `CCR_FC_HR_NONE;
      end else if (c == `CCR_FC_CODE_MAX) begin
         fc_hours = `CCR_FC_HR_MAX;
      end else begin
         fc_hours = {1'b0, c} + `CCR_FC_HR_OFFSET;
      end
   endfunction

   function automatic logic [7:0] rstrt_mv(input logic [1:0] c);
      case (c)
         2'h0: rstrt_mv = `CCR_RSTRT_MV0;
         2'h1: rstrt_mv = `CCR_RSTRT_MV1;
         2'h2: rstrt_mv = `CCR_RSTRT_MV2;
         default: rstrt_mv = `CCR_RSTRT_MV_NONE;
      endcase
   endfunction

   // ==========================================================
   // pin synchroniser
   logic pin_s1_q;
   logic pin_s2_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= battery_switch_disable_pin_in;
         pin_s2_q <= pin_s1_q;
      end
   end

   // ==========================================================
   // configuration storage
   logic swoff_q;
   logic stby_q;
   logic watchdog_enable_bit_q;
   ccr_mode_t mode_q;
   ccr_byte_t cfg1_q;
   logic wr_cfg0;
   logic wr_cfg1;
   logic swoff_eff;

   assign wr_cfg0 = reg_wr_in && (reg_addr_in == `CCR_ADDR_CFG0);
   assign wr_cfg1 = reg_wr_in && (reg_addr_in == `CCR_ADDR_CFG1);
   assign swoff_eff = swoff_q || pin_s2_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         swoff_q <= 1'b0;
         stby_q <= 1'b0;
         watchdog_enable_bit_q <= 1'b0;
         mode_q <= `CCR_RST_MODE;
      end else if (wr_cfg0) begin
         swoff_q <= reg_wdata_in[`CCR_B_SWOFF];
         stby_q <= reg_wdata_in[`CCR_B_STBY];
         watchdog_enable_bit_q <= reg_wdata_in[`CCR_B_WDT];
         // reserved codes leave the applied mode alone
         if (!mode_reserved(reg_wdata_in[`CCR_MODE_HI:`CCR_MODE_LO])) begin
            mode_q <= reg_wdata_in[`CCR_MODE_HI:`CCR_MODE_LO];
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg1_q <= `CCR_RST_CFG1;
      end else if (wr_cfg1) begin
         cfg1_q <= reg_wdata_in;
      end
   end

   // ==========================================================
   // register read port
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= 8'h00;
         reg_ack_out <= 1'b0;
      end else begin
         reg_ack_out <= reg_rd_in || reg_wr_in;
         if (reg_rd_in && reg_addr_in == `CCR_ADDR_CFG0) begin
            // readback shows what is applied, not what was written
            reg_rdata_out <= {1'b0, swoff_eff, stby_q, watchdog_enable_bit_q, mode_q};
         end else if (reg_rd_in && reg_addr_in == `CCR_ADDR_CFG1) begin
            reg_rdata_out <= cfg1_q;
         end else begin
            reg_rdata_out <= 8'h00;
         end
      end
   end

   // ==========================================================
   // watchdog
   logic [WDT_W-1:0] wdt_cnt_q;
   logic wdt_term;

   assign wdt_term = (wdt_cnt_q == WDT_W'(WDT_CYCLES - 1));

   // expiry in the clear cycle still sets the flag; a held terminal count must not block later clears
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wdt_cnt_q <= '0;
         watchdog_expired_out <= 1'b0;
      end else if (!watchdog_enable_bit_q) begin
         wdt_cnt_q <= '0;
         watchdog_expired_out <= 1'b0;
      end else begin
         if (watchdog_clear_in) begin
            wdt_cnt_q <= '0;
         end else if (!wdt_term) begin
            wdt_cnt_q <= wdt_cnt_q + 1'b1;
         end
         if (wdt_term && !watchdog_expired_out) begin
            watchdog_expired_out <= 1'b1;
         end else if (watchdog_clear_in) begin
            watchdog_expired_out <= 1'b0;
         end
      end
   end

   // ==========================================================
   // power-path decode
   logic chg_d;
   logic dcdc_d;
   logic otg_d;

   always_comb begin
      chg_d = 1'b0;
      dcdc_d = 1'b0;
      otg_d = 1'b0;
      if (mode_q <= `CCR_MODE_OFF_HI) begin
         chg_d = 1'b0;
      end else if (mode_q == `CCR_MODE_DCDC) begin
         dcdc_d = 1'b1;
      end else if (mode_q <= `CCR_MODE_CHG_HI) begin
         chg_d = 1'b1;
         dcdc_d = 1'b1;
      end else if (mode_q == `CCR_MODE_OTG) begin
         otg_d = 1'b1;
      end
      // standby shuts the converter in every direction
      if (stby_q) begin
         chg_d = 1'b0;
         dcdc_d = 1'b0;
         otg_d = 1'b0;
      end
      // lapsed watchdog stops charging only, system stays powered
      if (watchdog_expired_out) begin
         chg_d = 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         charger_en_out <= 1'b0;
         dcdc_en_out <= 1'b0;
         otg_en_out <= 1'b0;
         batt_sys_switch_off_out <= 1'b0;
         batt_switch_keep_on_out <= 1'b0;
         input_standby_force_out <= 1'b0;
      end else begin
         charger_en_out <= chg_d;
         dcdc_en_out <= dcdc_d;
         otg_en_out <= otg_d;
         batt_sys_switch_off_out <= swoff_eff;
         batt_switch_keep_on_out <= otg_d;
         input_standby_force_out <= stby_q;
      end
   end

   // ==========================================================
   // charge configuration outputs
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         prequal_enable_out <= 1'b0;
         prequal_timer_enable_out <= 1'b0;
         recharge_threshold_sel_out <= 2'h0;
         recharge_mv_per_cell_out <= 8'h00;
         stat_output_enable_out <= 1'b0;
         fast_charge_timeout_sel_out <= 3'h0;
         fast_charge_hours_out <= 4'h0;
      end else begin
         prequal_enable_out <= cfg1_q[`CCR_B_PREQUAL_ENABLE];
         prequal_timer_enable_out <= cfg1_q[`CCR_B_PQTMR];
         recharge_threshold_sel_out <= cfg1_q[`CCR_RSTRT_HI:`CCR_RSTRT_LO];
         recharge_mv_per_cell_out <= rstrt_mv(cfg1_q[`CCR_RSTRT_HI:`CCR_RSTRT_LO]);
         stat_output_enable_out <= cfg1_q[`CCR_B_STAT];
         fast_charge_timeout_sel_out <= cfg1_q[`CCR_FC_HI:`CCR_FC_LO];
         fast_charge_hours_out <= fc_hours(cfg1_q[`CCR_FC_HI:`CCR_FC_LO]);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   chk_swoff_pin_or: assert property (
      (swoff_q || pin_s2_q) |=> batt_sys_switch_off_out)
      else $error("switch off not driven from bit or pin");

   chk_swoff_readback: assert property (
      (reg_rd_in && reg_addr_in == `CCR_ADDR_CFG0) |=> reg_rdata_out[`CCR_B_SWOFF] == $past(swoff_eff))
      else $error("switch off readback wrong");

   chk_stby_dcdc_off: assert property (
      (wr_cfg0 && reg_wdata_in[`CCR_B_STBY]) |=> ##1 (!dcdc_en_out && !charger_en_out && input_standby_force_out))
      else $error("standby did not force converter off");

   chk_stby_readback: assert property (
      (reg_rd_in && reg_addr_in == `CCR_ADDR_CFG0) |=> reg_rdata_out[`CCR_B_STBY] == $past(stby_q))
      else $error("standby readback wrong");

   chk_wdt_expiry_time: assert property (
      (watchdog_enable_bit_q && !watchdog_clear_in && wdt_term) |=> watchdog_expired_out ##1 !charger_en_out)
      else $error("watchdog expiry did not stop charger");

   chk_wdt_clear_flag: assert property (
      (watchdog_enable_bit_q && watchdog_clear_in && watchdog_expired_out) |=> !watchdog_expired_out)
      else $error("watchdog clear did not drop expiry");

   chk_mode_off: assert property (
      (mode_q <= `CCR_MODE_OFF_HI) |=> (!charger_en_out && !dcdc_en_out && !otg_en_out))
      else $error("off mode left converter running");

   chk_mode_dcdc: assert property (
      (mode_q == `CCR_MODE_DCDC && !stby_q) |=> (dcdc_en_out && !charger_en_out && !otg_en_out))
      else $error("dcdc mode decode wrong");

   chk_mode_charge: assert property (
      (mode_q >= `CCR_MODE_CHG_LO && mode_q <= `CCR_MODE_CHG_HI && !stby_q && !watchdog_expired_out)
      |=> (charger_en_out && dcdc_en_out && !otg_en_out))
      else $error("charge mode decode wrong");

   chk_mode_otg: assert property (
      (mode_q == `CCR_MODE_OTG && !stby_q) |=> (otg_en_out && batt_switch_keep_on_out && !dcdc_en_out))
      else $error("otg mode decode wrong");

   chk_mode_readback: assert property (
      (reg_rd_in && reg_addr_in == `CCR_ADDR_CFG0) |=> reg_rdata_out[`CCR_MODE_HI:`CCR_MODE_LO] == $past(mode_q))
      else $error("mode readback wrong");

   chk_mode_reserved: assert property (
      (wr_cfg0 && mode_reserved(reg_wdata_in[`CCR_MODE_HI:`CCR_MODE_LO])) |=> $stable(mode_q))
      else $error("reserved mode was applied");

   chk_cfg1_write: assert property (
      wr_cfg1 |=> ##1 (prequal_enable_out == $past(reg_wdata_in[`CCR_B_PREQUAL_ENABLE], 2)
      && stat_output_enable_out == $past(reg_wdata_in[`CCR_B_STAT], 2)))
      else $error("config 1 write not applied");

   chk_rstrt_decode: assert property (
      (cfg1_q[`CCR_RSTRT_HI:`CCR_RSTRT_LO] == `CCR_RSTRT_OFF) |=> recharge_mv_per_cell_out == `CCR_RSTRT_MV_NONE)
      else $error("recharge disable decode wrong");

   chk_fc_hours: assert property (
      (cfg1_q[`CCR_FC_HI:`CCR_FC_LO] == `CCR_FC_CODE_MAX) |=> fast_charge_hours_out == `CCR_FC_HR_MAX)
      else $error("fast charge hours decode wrong");

endmodule // ccr_charger_config_regs

// file: testbench/ccr_host_model.sv
// host model that drives the byte register port and the watchdog clear
`timescale 1ns/1ps
module ccr_host_model (
   input wire logic clk_in,
   input wire logic reg_ack_in,
   input wire logic [7:0] reg_rdata_in,
   output logic [7:0] reg_addr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic watchdog_clear_out
);
   // ==========================================================
   // idle values
   initial begin
      reg_addr_out = 8'h00;
      reg_wdata_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      watchdog_clear_out = 1'b0;
   end

   // ==========================================================
   // one byte access; request held across the taking edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic k);
      @(negedge clk_in);
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = wr;
      reg_rd_out = !wr;
      @(negedge clk_in);
      q = reg_rdata_in;
      k = reg_ack_in;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      // released lines must not keep showing the last value
      reg_addr_out = ~a;
      reg_wdata_out = ~d;
   endtask

   // ==========================================================
   // watchdog restart, as a one-cycle pulse on the watchdog clear line
   task automatic pulse_clear();
      @(negedge clk_in);
      watchdog_clear_out = 1'b1;
      @(negedge clk_in);
      watchdog_clear_out = 1'b0;
   endtask
endmodule // ccr_host_model

// file: testbench/test_charger_config_regs.sv
// self-checking testbench for the charger configuration registers
`timescale 1ns/1ps
module test_charger_config_regs;
   import ccr_pkg::*;
   logic clk_in, rst_in, pin, clr, wr, rd, ack, sw_off, keep_on, stby, chg, dcdc, otg, wdx, pq, pqt, stat;
   logic [7:0] addr, wdata, rdata, mv, d, q;
   logic [1:0] rsel;
   logic [2:0] fsel;
   logic [3:0] hrs, md;
   logic sw, sb, wd, k;
   int num_errors = 0;
   int n_checks = 0;

   // ==========================================================
   // clock, design and host
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   ccr_charger_config_regs #(.WDT_CYCLES(16), .WDT_W(27)) ccr_charger_config_regs_i (
      .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_ack_out(ack), .battery_switch_disable_pin_in(pin),
      .watchdog_clear_in(clr), .batt_sys_switch_off_out(sw_off), .batt_switch_keep_on_out(keep_on),
      .input_standby_force_out(stby), .charger_en_out(chg), .dcdc_en_out(dcdc), .otg_en_out(otg),
      .watchdog_expired_out(wdx), .prequal_enable_out(pq), .prequal_timer_enable_out(pqt),
      .recharge_threshold_sel_out(rsel), .recharge_mv_per_cell_out(mv), .stat_output_enable_out(stat),
      .fast_charge_timeout_sel_out(fsel), .fast_charge_hours_out(hrs));
   ccr_host_model ccr_host_model_i (
      .clk_in(clk_in), .reg_ack_in(ack), .reg_rdata_in(rdata), .reg_addr_out(addr), .reg_wdata_out(wdata),
      .reg_wr_out(wr), .reg_rd_out(rd), .watchdog_clear_out(clr));

   // ==========================================================
   // expectations
   function automatic logic [7:0] cfg0_exp();
      return {1'b0, sw | pin, sb, wd, md};
   endfunction
   function automatic logic [7:0] pp_exp(input logic x);
      return {4'h0, md inside {[4'h5:4'h7]} && !sb && !x, md inside {[4'h4:4'h7]} && !sb,
              md == 4'ha && !sb, md == 4'ha && !sb};
   endfunction
   function automatic logic [7:0] mv_exp(input logic [1:0] s);
      return s == 2'h0 ? 8'h64 : s == 2'h1 ? 8'h96 : s == 2'h2 ? 8'hc8 : 8'h00;
   endfunction
   function automatic logic [7:0] hr_exp(input logic [2:0] f);
      return f == 3'h0 ? 8'h00 : f == 3'h7 ? 8'h0a : {5'h00, f} + 8'h02;
   endfunction

   // ==========================================================
   // shared checks and accesses
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         num_errors++;
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      ccr_host_model_i.xfer(1'b1, a, v, q, k);
      chk({7'h00, k}, 8'h01);
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      ccr_host_model_i.xfer(1'b0, a, 8'h00, q, k);
      chk({7'h00, k}, 8'h01);
      chk(q, exp);
   endtask
   task automatic put0(input logic [7:0] v);
      wr_reg(8'h16, v);
      sw = v[6];
      sb = v[5];
      wd = v[4];
      if (!(v[3:0] inside {4'h8, 4'h9, [4'hb:4'hf]})) md = v[3:0];
      @(negedge clk_in);
      chk({4'h0, chg, dcdc, otg, keep_on}, pp_exp(1'b0));
      chk({6'h00, sw_off, stby}, {6'h00, sw | pin, sb});
      rd_reg(8'h16, cfg0_exp());
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ==========================================================
   // tests
   initial begin
      rst_in = 1'b1;
      pin = 1'b0;
      {sw, sb, wd, md} = {3'h0, 4'h5};
      repeat (3) @(negedge clk_in);
      rst_in = 1'b0;
      void'($urandom(20186));
      @(negedge clk_in);
      rd_reg(8'h16, 8'h05);
      rd_reg(8'h17, 8'hd9);
      chk({pq, pqt, rsel, stat, fsel}, 8'hd9);
      chk({4'h0, chg, dcdc, otg, keep_on}, pp_exp(1'b0));
      $display("test reset done");
      for (int i = 0; i < 26; i++) begin
         d = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom());
         wr_reg(8'h17, d);
         @(negedge clk_in);
         chk({pq, pqt, rsel, stat, fsel}, d);
         chk(mv, mv_exp(d[5:4]));
         chk({4'h0, hrs}, hr_exp(d[2:0]));
         rd_reg(8'h17, d);
      end
      $display("test config1 done");
      for (int i = 0; i < 32; i++) begin
         d = 8'($urandom());
         put0({d[7:6], i[4], 1'b0, i[3:0]});
      end
      $display("test modes done");
      put0(8'h04);
      pin = 1'b1;
      repeat (4) @(negedge clk_in);
      chk({7'h00, sw_off}, 8'h01);
      rd_reg(8'h16, cfg0_exp());
      pin = 1'b0;
      repeat (4) @(negedge clk_in);
      rd_reg(8'h16, cfg0_exp());
      $display("test pin done");
      rd_reg(8'h20, 8'h00);
      wr_reg(8'h20, 8'hff);
      rd_reg(8'h16, cfg0_exp());
      $display("test unmapped done");
      put0(8'h15);
      repeat (6) begin
         repeat (8) @(negedge clk_in);
         ccr_host_model_i.pulse_clear();
         chk({7'h00, wdx}, 8'h00);
      end
      repeat (20) @(negedge clk_in);
      chk({6'h00, wdx, chg}, {6'h00, 1'b1, 1'b0});
      ccr_host_model_i.pulse_clear();
      chk({7'h00, wdx}, 8'h00);
      @(negedge clk_in);
      chk({7'h00, chg}, 8'h01);
      put0(8'h05);
      $display("test watchdog done");
      wrap_up();
   end

   // ==========================================================
   // hang guard, far beyond the few hundred cycles needed
   initial begin
      #400us;
      num_errors++;
      wrap_up();
   end
endmodule // test_charger_config_regs
